// >>> src/srp_serial_register_port.sv
/*
  Serial register port: instruction decode, address generation, shift
  in and out, and hand-off of register writes and reads to the system
  clock domain. Assumes the register file sits outside and answers a
  read request with data in the same cycle that the request pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_serial_register_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic spi_clk,
  input wire logic port_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_read_out_pin,
  output logic serial_read_out_pin_oe,
  output logic wr_valid,
  output logic [srp_pkg::ADDR_W-1:0] wr_addr,
  output logic [srp_pkg::BYTE_W-1:0] wr_data,
  output logic rd_req,
  output logic [srp_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [srp_pkg::BYTE_W-1:0] rd_data,
  output logic cfg_bidir,
  output logic cfg_lsb_first
);
  import srp_pkg::*;

  // ****************************************************************
  // Link domain state
  // ****************************************************************
  srp_phase_e phase_r;            // Sequencer phase
  logic [2:0] bit_cnt_r;          // Bit position within the byte
  logic [BYTE_W-1:0] sh_r;        // Receive shift register
  logic rw_r;                     // Current cycle reads
  logic [1:0] left_r;             // Data bytes left after this one
  logic [ADDR_W-1:0] addr_r;      // Address of the current data byte
  logic cfg_bidir_r;              // Data pin also drives read data
  logic cfg_lsb_r;                // LSB-first shift order
  logic wr_tog_r;                 // Toggles once per written byte
  logic [ADDR_W-1:0] wr_addr_l;   // Held write address
  logic [BYTE_W-1:0] wr_data_l;   // Held write data
  logic rd_tog_r;                 // Toggles once per read request
  logic [ADDR_W-1:0] rd_addr_l;   // Held read address
  logic [BYTE_W-1:0] tx_r;        // Byte being sent
  logic out_r;                    // Bit on the read data pins

  // ****************************************************************
  // System domain state
  // ****************************************************************
  logic [BYTE_W-1:0] rd_hold_r;   // Read byte handed to the link
  logic [1:0] cfg_meta_r;         // Config sync, first stage
  logic [1:0] cfg_sync_r;         // Config sync, second stage
  logic wr_evt;                   // Write byte arrived
  logic rd_evt;                   // Read byte wanted

  // ****************************************************************
  // Link decode
  // ****************************************************************
  logic [BYTE_W-1:0] shift_nxt;   // Byte after this edge's bit
  logic byte_done;                // This edge takes a byte's last bit
  logic in_instr;                 // Instruction phase
  logic in_data;                  // Data phase
  logic instr_done;               // Instruction byte complete
  logic data_done;                // Data byte complete
  logic instr_rw;                 // Direction field of the new byte
  logic [1:0] instr_cnt;          // Byte count field of the new byte
  logic [ADDR_W-1:0] instr_addr;  // Start address field of the new byte
  logic [ADDR_W-1:0] addr_step;   // Following address
  logic wr_fire;                  // Write byte ready to hand off
  logic rd_fire;                  // Next read byte to fetch
  logic [ADDR_W-1:0] rd_addr_nxt; // Address of the byte to fetch
  logic cfg_hit;                  // Write lands on the config register
  logic rd_drive;                 // Read data on the pins now
  logic [BYTE_W-1:0] tx_cur;      // Byte supplying the next bit

  // Shift direction follows the bit-order setting
  assign shift_nxt = cfg_lsb_r ? {sdio_in, sh_r[BYTE_W-1:1]}
                               : {sh_r[BYTE_W-2:0], sdio_in}; // R19 R17
  assign byte_done = (bit_cnt_r == LAST_BIT);
  assign in_instr = (phase_r == PH_INSTR);
  assign in_data = (phase_r == PH_DATA);
  assign instr_done = in_instr && byte_done; // R1
  assign data_done = in_data && byte_done;
  // Instruction fields
  assign instr_rw = shift_nxt[INS_RW_BIT]; // R5
  assign instr_cnt = shift_nxt[INS_BYTE_COUNT_HI:INS_BYTE_COUNT_LO]; // R4
  assign instr_addr = shift_nxt[INS_START_ADDR_BIT4:INS_START_ADDR_BIT0]; // R6
  // Address generator direction comes from the shift order
  assign addr_step = srp_next_addr(addr_r, cfg_lsb_r); // R8 R9 R10 R11
  assign wr_fire = data_done && !rw_r; // R7 R3
  assign rd_fire = (instr_done && instr_rw) || (data_done && rw_r && left_r != 2'h0);
  assign rd_addr_nxt = instr_done ? instr_addr : addr_step; // R6
  assign cfg_hit = wr_fire && (addr_r == CFG_REG_ADDR); // R21
  // First bit of each read byte comes from the fetched word
  assign tx_cur = (bit_cnt_r == FIRST_BIT) ? rd_hold_r : tx_r;

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Read data drives only during a read data phase with select low
  assign rd_drive = !port_select_n && rw_r && in_data; // R15
  assign sdio_oe = rd_drive && cfg_bidir_r; // R17
  assign sdio_out = out_r;
  assign serial_read_out_pin_oe = rd_drive && !cfg_bidir_r; // R18
  assign serial_read_out_pin = out_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Rising-edge sequencer; a high select clears it at once.
  // Nothing here is gated by power-down, so the port always runs.
  always_ff @(posedge spi_clk or posedge port_select_n) begin // R12 R20
    if (port_select_n) begin // R2 R3
      phase_r <= PH_INSTR;
      bit_cnt_r <= FIRST_BIT;
      sh_r <= '0;
      rw_r <= 1'b0;
      left_r <= 2'h0;
      addr_r <= '0;
    end else begin
      sh_r <= shift_nxt;
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      if (instr_done) begin // R1
        phase_r <= PH_DATA;
        rw_r <= instr_rw; // R5
        left_r <= instr_cnt; // R4
        addr_r <= instr_addr; // R6
      end else if (data_done) begin
        // Last byte ends the transfer, else step the address
        if (left_r == 2'h0) begin
          phase_r <= PH_DONE;
        end else begin
          left_r <= 2'(left_r - 2'h1);
          addr_r <= addr_step; // R8 R9
        end
      end
    end
  end

  // Port configuration; srst returns these bits to their reset defaults
  always_ff @(posedge spi_clk or posedge srst) begin // R22
    if (srst) begin
      cfg_bidir_r <= CFG_BIDIR_RST;
      cfg_lsb_r <= CFG_LSB_FIRST_RST;
    end else if (cfg_hit) begin // R21
      cfg_bidir_r <= shift_nxt[CFG_BIDIR_BIT];
      cfg_lsb_r <= shift_nxt[CFG_LSB_FIRST_BIT];
    end
  end

  // Held words and event toggles for the system domain
  always_ff @(posedge spi_clk or posedge srst) begin
    if (srst) begin
      wr_tog_r <= 1'b0;
      wr_addr_l <= '0;
      wr_data_l <= '0;
      rd_tog_r <= 1'b0;
      rd_addr_l <= '0;
    end else begin
      // Only complete bytes are handed over
      if (wr_fire) begin // R7 R3
        wr_tog_r <= !wr_tog_r;
        wr_addr_l <= addr_r;
        wr_data_l <= shift_nxt;
      end
      // Fetch the byte that goes out next
      if (rd_fire) begin // R23
        rd_tog_r <= !rd_tog_r;
        rd_addr_l <= rd_addr_nxt;
      end
    end
  end

  // ****************************************************************
  // Transmit on the falling edge
  // ****************************************************************
  // Loads a fetched byte at bit 0, then walks its bits
  always_ff @(negedge spi_clk or posedge port_select_n) begin // R13
    if (port_select_n) begin
      tx_r <= '0;
      out_r <= 1'b0;
    end else if (in_data && rw_r) begin // R23
      tx_r <= tx_cur;
      out_r <= srp_pick_bit(tx_cur, bit_cnt_r, cfg_lsb_r); // R19
    end
  end

  // ****************************************************************
  // System domain side
  // ****************************************************************
  srp_evt_sync u_wr_sync (
    .clock(clock),
    .srst(srst),
    .tog_in(wr_tog_r),
    .pulse(wr_evt)
  );

  srp_evt_sync u_rd_sync (
    .clock(clock),
    .srst(srst),
    .tog_in(rd_tog_r),
    .pulse(rd_evt)
  );

  // Write strobe with the held address and data
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_valid <= wr_evt; // R7
      if (wr_evt) begin
        wr_addr <= wr_addr_l;
        wr_data <= wr_data_l;
      end
    end
  end

  // Read request, and capture of the answer in the request cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_req <= 1'b0;
      rd_addr <= '0;
      rd_hold_r <= '0;
    end else begin
      rd_req <= rd_evt;
      if (rd_evt) begin
        rd_addr <= rd_addr_l;
      end
      if (rd_req) begin
        rd_hold_r <= rd_data;
      end
    end
  end

  // Config bits brought across as levels
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_meta_r <= '0;
      cfg_sync_r <= '0;
    end else begin
      cfg_meta_r <= {cfg_bidir_r, cfg_lsb_r};
      cfg_sync_r <= cfg_meta_r;
    end
  end

  assign cfg_bidir = cfg_sync_r[1];
  assign cfg_lsb_first = cfg_sync_r[0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_INSTR_LEN: assert property ( // R1
    @(posedge spi_clk) disable iff (port_select_n)
    instr_done |=> (phase_r == PH_DATA) && (bit_cnt_r == FIRST_BIT))
    else $error("instruction byte did not end after eight bits");

  AST_CS_IDLE: assert property ( // R2 R15
    @(posedge clock) disable iff (srst)
    port_select_n |-> in_instr && (bit_cnt_r == FIRST_BIT) && !sdio_oe
                      && !serial_read_out_pin_oe)
    else $error("port not idle while select is high");

  AST_NO_PARTIAL: assert property ( // R3 R7
    @(posedge spi_clk) disable iff (port_select_n || srst)
    !(in_data && byte_done && !rw_r) |=> $stable(wr_tog_r))
    else $error("write handed off without a full data byte");

  AST_BYTE_COUNT: assert property ( // R4
    @(posedge spi_clk) disable iff (port_select_n)
    instr_done |=> left_r == $past(instr_cnt))
    else $error("byte count not taken from instruction");

  AST_DIRECTION: assert property ( // R5
    @(posedge spi_clk) disable iff (port_select_n)
    instr_done |=> (rw_r == $past(instr_rw)) && (addr_r == $past(instr_addr)))
    else $error("direction or start address wrong");

  AST_ADDR_STEP: assert property ( // R8 R9 R10 R11
    @(posedge spi_clk) disable iff (port_select_n)
    (data_done && left_r != 2'h0) |=>
      addr_r == ($past(cfg_lsb_r) ? ADDR_W'($past(addr_r) + ADDR_STEP)
                                  : ADDR_W'($past(addr_r) - ADDR_STEP)))
    else $error("address generator stepped wrongly");

  AST_WR_STROBE: assert property ( // R7
    @(posedge clock) disable iff (srst)
    wr_evt |=> wr_valid && (wr_data == $past(wr_data_l)) ##1 !wr_valid)
    else $error("write strobe or data wrong");

  AST_SDO_QUIET: assert property ( // R18
    @(posedge clock) disable iff (srst)
    serial_read_out_pin_oe |-> !cfg_bidir)
    else $error("dedicated read pin driven in two-way mode");

  AST_SDIO_IN_ONLY: assert property ( // R17
    @(posedge clock) disable iff (srst)
    sdio_oe |-> cfg_bidir && !port_select_n)
    else $error("data pin driven while input only");

endmodule
`default_nettype wire

// >>> src/srp_pkg.sv
/*
  Constants, types and helpers shared by the serial register port.
  Assumes a byte-wide serial protocol with a 5-bit register address space.
*/
// How it works
// R1 - Instruction byte fills first eight rising edges
// R2 - Select high then low restarts instruction phase
// R3 - Aborted partial byte is never written
// R4 - Instruction bits 6:5 give one to four bytes
// R5 - Instruction bit 7 high reads, low writes
// R6 - Bits 4:0 start address, later addresses internal
// R7 - Each byte is written at its last bit
// R8 - LSB-first mode steps address up
// R9 - MSB-first mode steps address down
// R10 - Counting up from 1F gives 00
// R11 - Counting down from 00 gives 1F
// R12 - Inputs sampled and state advanced on rising edge
// R13 - Read bits change on the falling edge
// R14 - Master keeps serial clock at most 15 MHz
// R15 - Both data outputs float while select high
// R16 - Master holds select low for whole cycle
// R17 - Writes on data pin; config bit 7 makes it two-way
// R18 - Two-way mode keeps dedicated read pin floating
// R19 - Bit-order bit chooses LSB or MSB first
// R20 - Port keeps working in power-down
// R21 - Config bits 7:6 of 0x00 act immediately
// R22 - Software reset leaves register 0x00 alone; here srst clears its port bits 7:6
// R23 - First read byte starts on following falling edge
package srp_pkg;

  // ****************************************************************
  // Instruction and address layout
  // ****************************************************************
  localparam int ADDR_W = 5;                    // Register address width
  localparam int BYTE_W = 8;                    // Serial byte width
  localparam int INS_RW_BIT = 7;                // High reads, low writes
  localparam int INS_BYTE_COUNT_HI = 6;         // byte_count_hi position
  localparam int INS_BYTE_COUNT_LO = 5;         // byte_count_lo position
  localparam int INS_START_ADDR_BIT4 = 4;       // start_addr_bit4 position
  localparam int INS_START_ADDR_BIT0 = 0;       // start_addr_bit0 position
  localparam logic [2:0] LAST_BIT = 3'h7;       // Eighth bit of a byte
  localparam logic [2:0] FIRST_BIT = 3'h0;      // First bit of a byte
  localparam logic [ADDR_W-1:0] ADDR_STEP = 5'h01; // Address generator step

  // ****************************************************************
  // Port configuration register
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CFG_REG_ADDR = 5'h00; // Port config register
  localparam int CFG_BIDIR_BIT = 7;             // Data pin carries reads too
  localparam int CFG_LSB_FIRST_BIT = 6;         // Shift order select
  localparam logic CFG_BIDIR_RST = 1'b0;        // Input-only data pin
  localparam logic CFG_LSB_FIRST_RST = 1'b0;    // MSB first

  // ****************************************************************
  // Timing figures
  // ****************************************************************
  localparam int SCLK_MAX_MHZ = 15;             // Fastest serial clock
  localparam int CLOCK_MHZ = 100;               // System clock rate

  // Sequencer phases, Gray coded along the usual path
  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,                           // Shifting instruction byte
    PH_DATA = 2'b01,                            // Shifting data bytes
    PH_DONE = 2'b11                             // Transfer finished
  } srp_phase_e;

  // Next address of the internal generator, wrapping at both ends
  function automatic logic [ADDR_W-1:0] srp_next_addr(
    input logic [ADDR_W-1:0] addr,
    input logic up
  );
    srp_next_addr = up ? ADDR_W'(addr + ADDR_STEP) : ADDR_W'(addr - ADDR_STEP);
  endfunction

  // Bit of a byte that goes out at a given position in the shift order
  function automatic logic srp_pick_bit(
    input logic [BYTE_W-1:0] b,
    input logic [2:0] idx,
    input logic lsb_first
  );
    srp_pick_bit = lsb_first ? b[idx] : b[3'(LAST_BIT - idx)];
  endfunction

endpackage

// >>> src/srp_evt_sync.sv
/*
  Toggle-to-pulse event synchroniser into the system clock domain.
  Assumes the source toggles at most once per several destination cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_evt_sync (
  input wire logic clock,
  input wire logic srst,
  input wire logic tog_in,
  output logic pulse
);
  import srp_pkg::*;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  logic meta_r;   // First stage, read only by the second
  logic sync_r;   // Second stage
  logic hist_r;   // Previous synchronised level

  // Two flops then one history flop for the edge
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hist_r <= 1'b0;
    end else begin
      meta_r <= tog_in;
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  // One cycle pulse per source toggle
  assign pulse = sync_r ^ hist_r;

endmodule
`default_nettype wire

// >>> test/srp_host_model.sv
/*
  Serial master model for the serial register port: frames of select,
  clock and data, with read bytes handed back one at a time.
  Assumes the bench resolves the read line and supplies the shift modes.
*/
`timescale 1ns/1ps
`default_nettype none
module srp_host_model (
  input wire logic lsb,
  input wire logic bidir,
  input wire logic rline,
  output logic spi_clk,
  output logic port_select_n,
  output logic sdio_drv,
  output logic sdio_en,
  output logic rb_valid,
  output logic [7:0] rb
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // Clock parked low and select high between frames
  initial begin
    spi_clk = 1'b0;
    // Select starts low and rises at 1 ns, so the async clears see an edge
    port_select_n = 1'b0;
    sdio_drv = 1'b0;
    sdio_en = 1'b1;
    rb_valid = 1'b0;
    rb = 8'h00;
    #1 port_select_n = 1'b1;
  end

  // ****************************************************************
  // Frame task
  // ****************************************************************
  // One frame of 160 ns bits; a positive nbits below the full length aborts it
  task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input int nbits);
    int n;
    logic [7:0] cur;
    logic [7:0] sh;
    n = 8 * (32'(ins[6:5]) + 2);
    if (nbits <= 0 || nbits > n) begin
      nbits = n;
    end
    sh = 8'h00;
    cur = ins;
    // Odd offset keeps the link clock off the system clock's phase
    #43.3 port_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      if (i % 8 == 0 && i > 0) begin
        cur = wd[7:0];
        wd = wd >> 8;
      end
      // Line released to the device during a two-way read
      sdio_en = !(ins[7] && bidir && i >= 8);
      sdio_drv = lsb ? cur[i % 8] : cur[7 - i % 8];
      #40;
      // Read bit has stood since the last falling edge; take it before the rise
      if (ins[7] && i >= 8) begin
        sh = lsb ? {rline, sh[7:1]} : {sh[6:0], rline};
      end
      spi_clk = 1'b1;
      rb = sh;
      rb_valid = ins[7] && i >= 8 && i % 8 == 7;
      #80 spi_clk = 1'b0;
      rb_valid = 1'b0;
      #40;
    end
    port_select_n = 1'b1;
    sdio_en = 1'b1;
    // Released data shows the inverse of the last bit
    sdio_drv = ~sdio_drv;
    #300;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
/*
  Self-checking bench for the serial register port: host model on the
  link, register file model on the system side, queued expectations.
  Assumes the port design and its package are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srp_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0;
  logic srst = 1'b0; // Raised at 1 ns so the link-side async clears see an edge
  logic spi_clk, port_select_n, sdio_drv, sdio_en, sdio_in, sdio_out, sdio_oe;
  logic serial_read_out_pin, serial_read_out_pin_oe, wr_valid, rd_req, rline;
  logic cfg_bidir, cfg_lsb_first, rb_valid;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [BYTE_W-1:0] wr_data, rd_data, rb;
  logic [7:0] mem [32]; // Register file model
  logic [7:0] exp_mem [32]; // Expected register contents
  logic lsb = 1'b0; // Expected shift order
  logic bidir = 1'b0; // Expected data pin mode
  logic [15:0] wq[$]; // Expected writes {addr, data}
  logic [7:0] rq[$]; // Expected read bytes
  int errors = 0;
  int check_count = 0;

  always #5 clock = ~clock;

  // Device drives the shared pin when enabled, else the host or its ghost
  assign sdio_in = sdio_oe ? sdio_out : (sdio_en ? sdio_drv : ~sdio_drv);
  // Undriven read line reads unknown so a late enable is caught
  assign rline = bidir ? (sdio_oe ? sdio_out : 1'bx) :
                 (serial_read_out_pin_oe ? serial_read_out_pin : 1'bx);
  assign rd_data = mem[rd_addr];

  srp_serial_register_port uut (
    .clock, .srst, .spi_clk, .port_select_n, .sdio_in, .sdio_out, .sdio_oe,
    .serial_read_out_pin, .serial_read_out_pin_oe, .wr_valid, .wr_addr,
    .wr_data, .rd_req, .rd_addr, .rd_data, .cfg_bidir, .cfg_lsb_first
  );

  srp_host_model host (
    .lsb, .bidir, .rline, .spi_clk, .port_select_n, .sdio_drv, .sdio_en,
    .rb_valid, .rb
  );

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Register file takes each write; monitor matches it to the oldest note
  always @(posedge clock) begin
    if (wr_valid === 1'b1) begin
      mem[wr_addr] <= wr_data;
      if (wq.size() == 0) begin
        chk(16'h0001, 16'h0000, "unexpected write");
      end else begin
        chk({3'h0, wr_addr, wr_data}, wq.pop_front(), "write");
      end
    end
  end

  // Read bytes gathered by the host against the oldest note
  always @(posedge rb_valid) begin
    if (rq.size() == 0) begin
      chk(16'h0001, 16'h0000, "unexpected read");
    end else begin
      chk({8'h00, rb}, {8'h00, rq.pop_front()}, "read");
    end
  end

  // Pin enables against select and mode
  always @(posedge clock) begin
    if (srst === 1'b0 && port_select_n === 1'b1 &&
        (sdio_oe !== 1'b0 || serial_read_out_pin_oe !== 1'b0)) begin
      chk(16'h0001, 16'h0000, "pin driven while deselected");
    end
    if (srst === 1'b0 && bidir && serial_read_out_pin_oe !== 1'b0) begin
      chk(16'h0001, 16'h0000, "read pin driven in two-way mode");
    end
    if (srst === 1'b0 && !bidir && sdio_oe !== 1'b0) begin
      chk(16'h0001, 16'h0000, "data pin driven in one-way mode");
    end
  end

  // ****************************************************************
  // Transfer tasks
  // ****************************************************************
  // Write n bytes from a, noting each address the generator must produce
  task automatic wr(input logic [4:0] a, input int n, input logic [31:0] d);
    logic [31:0] t;
    t = d;
    for (int k = 0; k < n; k++) begin
      wq.push_back({3'h0, a, t[7:0]});
      exp_mem[a] = t[7:0];
      t = t >> 8;
      a = lsb ? a + 5'h01 : a - 5'h01;
    end
    @(posedge clock);
    #1 host.frame({1'b0, 2'(n - 1), a - 5'(lsb ? n : -n)}, d, 0);
  endtask

  // Read n bytes from a, noting the expected contents
  task automatic rd(input logic [4:0] a, input int n);
    logic [4:0] s;
    s = a;
    for (int k = 0; k < n; k++) begin
      rq.push_back(exp_mem[s]);
      s = lsb ? s + 5'h01 : s - 5'h01;
    end
    @(posedge clock);
    #1 host.frame({1'b1, 2'(n - 1), a}, 32'h0, 0);
    chk(16'(rq.size()), 16'h0000, "read bytes missing");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [4:0] a;
    // A real rising edge of reset clears the link-side flops
    #1 srst = 1'b1;
    void'($urandom(32'hD30E));
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    chk({14'h0, cfg_bidir, cfg_lsb_first}, 16'h0000, "config reset");
    // Second byte lands on the config register: keep its port bits at default
    wr(5'h01, 4, $urandom & 32'hFFFF3FFF);
    rd(5'h01, 4);
    for (int n = 1; n <= 4; n++) begin
      a = 5'($urandom_range(23, 8));
      wr(a, n, $urandom);
      rd(a, n);
    end
    @(posedge clock);
    #1 host.frame(8'h03, 32'hA5, 12);
    @(posedge clock);
    #1 host.frame(8'h03, 32'h5A, 5);
    rd(5'h03, 1);
    wr(5'h00, 1, 32'h40);
    lsb = 1'b1;
    chk({14'h0, cfg_bidir, cfg_lsb_first}, 16'h0001, "order bit");
    // Second byte lands on the config register: keep LSB first, one-way pin
    wr(5'h1F, 2, ($urandom & 32'hFFFF3FFF) | 32'h00004000);
    rd(5'h1F, 2);
    wr(5'h00, 1, 32'hC0);
    bidir = 1'b1;
    chk({14'h0, cfg_bidir, cfg_lsb_first}, 16'h0003, "pin mode");
    rd(5'h1E, 3);
    wr(5'h00, 1, 32'h00);
    lsb = 1'b0;
    bidir = 1'b0;
    rd(5'h02, 2);
    repeat (20) @(posedge clock);
    chk(16'(wq.size()), 16'h0000, "writes missing");
    conclude();
  end

  // Watchdog for a hung run
  initial begin
    #500000;
    chk(16'h0001, 16'h0000, "timeout");
    conclude();
  end
endmodule
`default_nettype wire
